/* File: shared/tps_pkg.sv */
// package of register map, field positions and constants for the touch panel sequencer
package tps_pkg;
    // register byte offsets (software view)
    localparam logic [7:0] OFS_SAR_CTRL      = 8'h00; // power-down, resolution, divider
    localparam logic [7:0] OFS_MODE_CTRL     = 8'h04; // start mode, scan function, pin select
    localparam logic [7:0] OFS_PEN_TIMING    = 8'h08; // detect disable, precharge, sense
    localparam logic [7:0] OFS_STAB_TIMING   = 8'h0c; // stabilization
    localparam logic [7:0] OFS_CLK_SEL       = 8'h10; // state-machine clock source
    localparam logic [7:0] OFS_PIN_FUNC_ONE  = 8'h14; // pin one function
    localparam logic [7:0] OFS_PIN_FUNC_TWO  = 8'h18; // pin two function
    localparam logic [7:0] OFS_STATUS        = 8'h1c; // read-only state
    localparam logic [7:0] OFS_RESULT_Y      = 8'h20;
    localparam logic [7:0] OFS_RESULT_X      = 8'h24;

    // field positions
    localparam int SAR_PWRDN_BIT   = 7;
    localparam int SAR_RES_LSB     = 5;
    localparam int SAR_DIV_LSB     = 3;
    localparam int MODE_HOST_BIT   = 7;
    localparam int MODE_FUNC_LSB   = 2;
    localparam int MODE_PINSEL_LSB = 0;
    localparam int PEN_DIS_BIT     = 7;
    localparam int PEN_PRE_LSB     = 4;
    localparam int PEN_SENSE_LSB   = 0;
    localparam int STAB_LSB        = 0;
    localparam int CLK_SEL_BIT     = 7;
    localparam int PIN_FUNC_LSB    = 2;

    // field values
    localparam logic [3:0] PIN_FUNC_INDICATION = 4'hc;
    localparam logic [3:0] SCAN_FUNC_XY        = 4'h1;
    localparam logic [1:0] PINSEL_PEN          = 2'h0;
    localparam logic [1:0] PINSEL_RESULT       = 2'h1;
    localparam logic [1:0] PINSEL_EITHER       = 2'h2;

    // reset values
    localparam logic [7:0] RST_SAR_CTRL    = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL   = 8'h00;
    localparam logic [7:0] RST_PEN_TIMING  = 8'h00;
    localparam logic [7:0] RST_STAB_TIMING = 8'h00;
    localparam logic [7:0] RST_CLK_SEL     = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC    = 8'h00;

    // timing: phase length unit and base cycles per converter clock
    localparam int PHASE_UNIT_CYCLES = 4;  // converter clocks per field step
    localparam int CONV_CYCLES_BASE  = 4;  // converter clocks of sampling per bit group
    localparam int OSC_FREQ_KHZ      = 8200;
    localparam int REF_CLK_KHZ       = 50000;
    localparam int OSC_DIV_CYCLES    = (REF_CLK_KHZ + OSC_FREQ_KHZ - 1) / OSC_FREQ_KHZ;

    typedef enum logic [3:0] {
        TPS_IDLE, TPS_WAIT_HOST, TPS_Y_STAB, TPS_Y_CONV, TPS_PRECHARGE,
        TPS_SENSE, TPS_X_STAB, TPS_X_CONV, TPS_STORE
    } tps_state_e;
endpackage

/* File: src/tps_clk_div.sv */
// converter clock tick generator: source select and divide
`timescale 1ns/1ps
`default_nettype none
module tps_clk_div #(
    parameter int OSC_DIV = 7
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       use_ext_clk,
    input  wire logic       ext_clk_tick,
    input  wire logic [1:0] div_sel,
    output logic            src_tick,
    output logic            conv_tick
);
    logic [7:0] osc_cnt_r;
    logic [3:0] div_cnt_r;
    logic       osc_tick;
    logic [3:0] div_limit;

    // internal oscillator modelled as a ref_clk divider
    assign osc_tick  = (osc_cnt_r == 8'(OSC_DIV - 1));
    assign src_tick  = use_ext_clk ? ext_clk_tick : osc_tick;
    assign div_limit = 4'((4'h1 << div_sel) - 4'h1);
    assign conv_tick = src_tick && (div_cnt_r >= div_limit);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            osc_cnt_r <= 8'h00;
        else
            osc_cnt_r <= osc_tick ? 8'h00 : osc_cnt_r + 8'h01;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            div_cnt_r <= 4'h0;
        else if (conv_tick)
            div_cnt_r <= 4'h0;
        else if (src_tick)
            div_cnt_r <= div_cnt_r + 4'h1;
    end
endmodule
`default_nettype wire

/* File: src/tps_sequencer.sv */
// touch panel conversion sequencer with apb registers
// Functional notes
// - clock source chosen by select bit
// - converter clock divided by divider field
// - internal oscillator nominal 8.2 MHz
// - function code 1100 routes indication pin
// - indication selects pen, result or either
// - idle grounds Y-, pulls X+ up
// - X+ detached from detector while measuring
// - debounce runs on selected source clock
// - recheck reconnects pull-up, precharges, senses
// - phase durations come from timing fields
// - detect disable bit blocks pen detection
// - mode bit selects touch or host start
// - touch start lowers pin, starts oscillator
// - Y stabilize, convert, recheck, then X
// - touch mode repeats while touched
// - host write of scan function starts
// - power-down bit ends any sequence
// - resolution field selects 8/10/12 bits
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tps_sequencer #(
    parameter int RES_W = 12
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              ext_clk_tick,
    input  wire logic              pen_sense_in,
    output logic                   y_drive_en,
    output logic                   x_drive_en,
    output logic                   pullup_en,
    output logic                   precharge_en,
    output logic                   panel_ground_return_en,
    output logic                   osc_run,
    output logic                   conv_start,
    output logic [1:0]             conv_res,
    output logic                   conv_is_x,
    input  wire logic              conv_done,
    input  wire logic [RES_W-1:0]  conv_data,
    output logic                   multipurpose_pin_one,
    output logic                   multipurpose_pin_two
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]       sar_ctrl_r, mode_ctrl_r, pen_timing_r, stab_timing_r, clk_sel_r;
    logic [7:0]       pin_func_one_r, pin_func_two_r;
    logic [RES_W-1:0] result_y_r, result_x_r;
    logic             result_ready_flag_r;
    logic             host_start_r;
    logic [2:0]       pen_sync_r;
    logic             pen_stable_r;
    tps_pkg::tps_state_e state_r, state_nxt;
    logic [9:0]       phase_cnt_r, phase_cnt_nxt;
    logic             conv_start_r;
    logic [RES_W-1:0] data_y_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_en      = psel && penable && pwrite;
    wire rd_access  = psel && penable && !pwrite;
    wire addr_known = (paddr <= tps_pkg::OFS_RESULT_X) && (paddr[1:0] == 2'h0);
    wire wr_mode    = wr_en && (paddr == tps_pkg::OFS_MODE_CTRL);
    wire wr_status  = rd_access && (paddr == tps_pkg::OFS_STATUS);
    wire host_mode  = mode_ctrl_r[tps_pkg::MODE_HOST_BIT];
    wire pwr_down   = sar_ctrl_r[tps_pkg::SAR_PWRDN_BIT];
    wire pen_dis    = pen_timing_r[tps_pkg::PEN_DIS_BIT];
    wire scan_write = wr_mode && (pwdata[tps_pkg::MODE_FUNC_LSB +: 4] == tps_pkg::SCAN_FUNC_XY);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_known;

    function automatic logic [7:0] bus_wr(input logic [7:0] old, input logic [7:0] ofs);
        bus_wr = (wr_en && paddr == ofs) ? pwdata[7:0] : old;
    endfunction

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sar_ctrl_r     <= tps_pkg::RST_SAR_CTRL;
            mode_ctrl_r    <= tps_pkg::RST_MODE_CTRL;
            pen_timing_r   <= tps_pkg::RST_PEN_TIMING;
            stab_timing_r  <= tps_pkg::RST_STAB_TIMING;
            clk_sel_r      <= tps_pkg::RST_CLK_SEL;
            pin_func_one_r <= tps_pkg::RST_PIN_FUNC;
            pin_func_two_r <= tps_pkg::RST_PIN_FUNC;
        end
        else
        begin
            sar_ctrl_r     <= bus_wr(sar_ctrl_r, tps_pkg::OFS_SAR_CTRL);
            mode_ctrl_r    <= bus_wr(mode_ctrl_r, tps_pkg::OFS_MODE_CTRL);
            pen_timing_r   <= bus_wr(pen_timing_r, tps_pkg::OFS_PEN_TIMING);
            stab_timing_r  <= bus_wr(stab_timing_r, tps_pkg::OFS_STAB_TIMING);
            clk_sel_r      <= bus_wr(clk_sel_r, tps_pkg::OFS_CLK_SEL);
            pin_func_one_r <= bus_wr(pin_func_one_r, tps_pkg::OFS_PIN_FUNC_ONE);
            pin_func_two_r <= bus_wr(pin_func_two_r, tps_pkg::OFS_PIN_FUNC_TWO);
        end
    end

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            tps_pkg::OFS_SAR_CTRL:     rd_mux[7:0] = sar_ctrl_r;
            tps_pkg::OFS_MODE_CTRL:    rd_mux[7:0] = mode_ctrl_r;
            tps_pkg::OFS_PEN_TIMING:   rd_mux[7:0] = pen_timing_r;
            tps_pkg::OFS_STAB_TIMING:  rd_mux[7:0] = stab_timing_r;
            tps_pkg::OFS_CLK_SEL:      rd_mux[7:0] = clk_sel_r;
            tps_pkg::OFS_PIN_FUNC_ONE: rd_mux[7:0] = pin_func_one_r;
            tps_pkg::OFS_PIN_FUNC_TWO: rd_mux[7:0] = pin_func_two_r;
            tps_pkg::OFS_STATUS:       rd_mux[7:0] = {2'h0, pen_stable_r, result_ready_flag_r, state_r};
            tps_pkg::OFS_RESULT_Y:     rd_mux[RES_W-1:0] = result_y_r;
            tps_pkg::OFS_RESULT_X:     rd_mux[RES_W-1:0] = result_x_r;
            default:                   rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    logic src_tick, conv_tick;
    tps_clk_div #(
        .OSC_DIV (tps_pkg::OSC_DIV_CYCLES)
    ) u_clk_div (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .use_ext_clk  (clk_sel_r[tps_pkg::CLK_SEL_BIT]),
        .ext_clk_tick (ext_clk_tick),
        .div_sel      (sar_ctrl_r[tps_pkg::SAR_DIV_LSB +: 2]),
        .src_tick     (src_tick),
        .conv_tick    (conv_tick)
    );

    // ------------------------------------------------------------
    // pen detect and debounce
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pen_sync_r   <= 3'h7;
            pen_stable_r <= 1'b1;
        end
        else
        begin
            pen_sync_r <= {pen_sync_r[1:0], pen_sense_in};
            if (src_tick && (pen_sync_r[2] == pen_sync_r[1]))
                pen_stable_r <= pen_sync_r[2];
        end
    end

    // low on sense means touched; blocked when detection is off
    wire touched = !pen_stable_r && !pen_dis;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wire [9:0] stab_len  = 10'({stab_timing_r[tps_pkg::STAB_LSB +: 3], 2'h0}) + 10'h004;
    wire [9:0] pre_len   = 10'({pen_timing_r[tps_pkg::PEN_PRE_LSB +: 3], 2'h0}) + 10'h004;
    wire [9:0] sense_len = 10'({pen_timing_r[tps_pkg::PEN_SENSE_LSB +: 3], 2'h0}) + 10'h004;
    wire       phase_end = conv_tick && (phase_cnt_r == 10'h001);
    wire       in_seq    = (state_r != tps_pkg::TPS_IDLE) && (state_r != tps_pkg::TPS_WAIT_HOST);

    always_comb
    begin
        state_nxt     = state_r;
        phase_cnt_nxt = (conv_tick && phase_cnt_r != 10'h000) ? phase_cnt_r - 10'h001 : phase_cnt_r;
        unique case (state_r)
            tps_pkg::TPS_IDLE:
                if (touched && !pwr_down)
                begin
                    state_nxt     = host_mode ? tps_pkg::TPS_WAIT_HOST : tps_pkg::TPS_Y_STAB;
                    phase_cnt_nxt = stab_len;
                end
            tps_pkg::TPS_WAIT_HOST:
                if (scan_write)
                begin
                    state_nxt     = tps_pkg::TPS_Y_STAB;
                    phase_cnt_nxt = stab_len;
                end
                else if (!touched)
                    state_nxt = tps_pkg::TPS_IDLE;
            tps_pkg::TPS_Y_STAB:
                if (phase_end)
                    state_nxt = tps_pkg::TPS_Y_CONV;
            tps_pkg::TPS_Y_CONV:
                if (conv_done)
                begin
                    state_nxt     = tps_pkg::TPS_PRECHARGE;
                    phase_cnt_nxt = pre_len;
                end
            tps_pkg::TPS_PRECHARGE:
                if (phase_end)
                begin
                    state_nxt     = tps_pkg::TPS_SENSE;
                    phase_cnt_nxt = sense_len;
                end
            tps_pkg::TPS_SENSE:
                if (phase_end)
                begin
                    state_nxt     = touched ? tps_pkg::TPS_X_STAB : tps_pkg::TPS_IDLE;
                    phase_cnt_nxt = stab_len;
                end
            tps_pkg::TPS_X_STAB:
                if (phase_end)
                    state_nxt = tps_pkg::TPS_X_CONV;
            tps_pkg::TPS_X_CONV:
                if (conv_done)
                    state_nxt = tps_pkg::TPS_STORE;
            tps_pkg::TPS_STORE:
            begin
                // repeat only in touch mode with touch still present
                state_nxt     = (!host_mode && touched) ? tps_pkg::TPS_Y_STAB : tps_pkg::TPS_IDLE;
                phase_cnt_nxt = stab_len;
            end
            default:
                state_nxt = tps_pkg::TPS_IDLE;
        endcase
        if (pwr_down)
            state_nxt = tps_pkg::TPS_IDLE;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r     <= tps_pkg::TPS_IDLE;
            phase_cnt_r <= 10'h000;
        end
        else
        begin
            state_r     <= state_nxt;
            phase_cnt_r <= phase_cnt_nxt;
        end
    end

    // one-cycle start on entering a conversion state
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            conv_start_r <= 1'b0;
        else
            conv_start_r <= (state_nxt != state_r) &&
                            (state_nxt == tps_pkg::TPS_Y_CONV || state_nxt == tps_pkg::TPS_X_CONV);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_y_r   <= '0;
            result_y_r <= '0;
            result_x_r <= '0;
        end
        else
        begin
            if (state_r == tps_pkg::TPS_Y_CONV && conv_done)
                data_y_r <= conv_data;
            if (state_r == tps_pkg::TPS_X_CONV && conv_done)
            begin
                result_y_r <= data_y_r;
                result_x_r <= conv_data;
            end
        end
    end

    // set wins over the clearing status read
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            result_ready_flag_r <= 1'b0;
        else if (state_r == tps_pkg::TPS_STORE)
            result_ready_flag_r <= 1'b1;
        else if (wr_status)
            result_ready_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            host_start_r <= 1'b0;
        else
            host_start_r <= in_seq;
    end

    // ------------------------------------------------------------
    // panel drivers and converter
    // ------------------------------------------------------------
    wire measuring = (state_r == tps_pkg::TPS_Y_STAB) || (state_r == tps_pkg::TPS_Y_CONV) ||
                     (state_r == tps_pkg::TPS_X_STAB) || (state_r == tps_pkg::TPS_X_CONV);

    assign y_drive_en   = (state_r == tps_pkg::TPS_Y_STAB) || (state_r == tps_pkg::TPS_Y_CONV);
    assign x_drive_en   = (state_r == tps_pkg::TPS_X_STAB) || (state_r == tps_pkg::TPS_X_CONV);
    assign panel_ground_return_en = !measuring && !pen_dis;
    assign pullup_en    = !measuring && !pen_dis;
    assign precharge_en = (state_r == tps_pkg::TPS_PRECHARGE);
    assign osc_run      = touched || host_start_r;
    assign conv_start   = conv_start_r;
    assign conv_res     = sar_ctrl_r[tps_pkg::SAR_RES_LSB +: 2];
    assign conv_is_x    = x_drive_en;

    // ------------------------------------------------------------
    // indication pins, active low
    // ------------------------------------------------------------
    logic [1:0] pin_sel;
    logic       indication_n;
    assign pin_sel = mode_ctrl_r[tps_pkg::MODE_PINSEL_LSB +: 2];
    always_comb
    begin
        unique case (pin_sel)
            tps_pkg::PINSEL_RESULT: indication_n = !result_ready_flag_r;
            tps_pkg::PINSEL_EITHER: indication_n = !(touched || result_ready_flag_r);
            default:                indication_n = !touched;
        endcase
    end

    wire route_one = pin_func_one_r[tps_pkg::PIN_FUNC_LSB +: 4] == tps_pkg::PIN_FUNC_INDICATION;
    wire route_two = pin_func_two_r[tps_pkg::PIN_FUNC_LSB +: 4] == tps_pkg::PIN_FUNC_INDICATION;
    assign multipurpose_pin_one = route_one ? indication_n : 1'b0;
    assign multipurpose_pin_two = route_two ? indication_n : 1'b0;
endmodule
`default_nettype wire

/* File: dv/tps_seq_asserts.sv */
// port-level assertions for the touch panel sequencer
`timescale 1ns/1ps
`default_nettype none
module tps_seq_asserts (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        y_drive_en,
    input wire logic        x_drive_en,
    input wire logic        pullup_en,
    input wire logic        precharge_en,
    input wire logic        panel_ground_return_en,
    input wire logic        conv_start,
    input wire logic        conv_is_x,
    input wire logic [1:0]  conv_res
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // -------------------------------------------------------
    // sequences
    // -------------------------------------------------------
    sequence s_sar_wr;
        psel && penable && pwrite && paddr == tps_pkg::OFS_SAR_CTRL;
    endsequence
    sequence s_measuring;
        x_drive_en || y_drive_en;
    endsequence
    // -------------------------------------------------------
    // properties
    // -------------------------------------------------------
    property p_detach; s_measuring |-> !pullup_en && !precharge_en; endproperty
    a_detach: assert property (p_detach) else $error("pull-up on while measuring");
    property p_pull_gnd; pullup_en |-> panel_ground_return_en; endproperty
    a_pull_gnd: assert property (p_pull_gnd) else $error("pull-up without ground");
    property p_pre_after_y; $rose(precharge_en) |-> $past(y_drive_en); endproperty
    a_pre_after_y: assert property (p_pre_after_y) else $error("precharge not after y");
    property p_conv_y; conv_start && !conv_is_x |-> y_drive_en; endproperty
    a_conv_y: assert property (p_conv_y) else $error("y conversion without drive");
    property p_conv_x; conv_start && conv_is_x |-> x_drive_en; endproperty
    a_conv_x: assert property (p_conv_x) else $error("x conversion without drive");
    property p_pulse; conv_start |=> !conv_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
    property p_x_after_sense; $rose(x_drive_en) |-> $past(pullup_en) && !$past(precharge_en); endproperty
    a_x_after_sense: assert property (p_x_after_sense) else $error("x drive not after sense");
    property p_pwrdn; s_sar_wr ##0 pwdata[7] |-> ##[1:4] !(x_drive_en || y_drive_en); endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("power-down did not stop");
    property p_res; s_sar_wr |=> conv_res == $past(pwdata[6:5]); endproperty
    a_res: assert property (p_res) else $error("resolution not taken");
endmodule
`default_nettype wire

/* File: dv/tps_panel_model.sv */
// panel and converter model at the sequencer's far side
`timescale 1ns/1ps
`default_nettype none
module tps_panel_model (
    input  wire logic        ref_clk,
    input  wire logic        touched,
    input  wire logic        pullup_en,
    input  wire logic        panel_ground_return_en,
    input  wire logic        conv_start,
    input  wire logic        conv_is_x,
    input  wire logic [11:0] x_val,
    input  wire logic [11:0] y_val,
    input  wire logic [3:0]  lat,
    output logic             pen_sense_in,
    output var logic         conv_done,
    output var logic [11:0]  conv_data
);
    logic [3:0]  cnt = 4'h0;
    logic        toggle = 1'b0;
    logic [11:0] held = 12'h000;
    // floating x+ shows no stable level once the pull-up is off
    assign pen_sense_in = pullup_en ? !(touched && panel_ground_return_en) : toggle;
    initial
    begin
        conv_done = 1'b0;
        conv_data = 12'h000;
    end
    always @(posedge ref_clk)
    begin
        toggle <= !toggle;
        conv_done <= 1'b0;
        conv_data <= ~held;
        if (conv_start)
        begin
            cnt <= lat;
            held <= conv_is_x ? x_val : y_val;
        end
        else if (cnt == 4'h1)
        begin
            cnt <= 4'h0;
            conv_done <= 1'b1;
            conv_data <= held;
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule
`default_nettype wire

/* File: dv/touch_panel_conversion_sequencer_bench.sv */
// self-checking bench for the touch panel sequencer
`timescale 1ns/1ps
`default_nettype none
module touch_panel_conversion_sequencer_bench;
    logic        ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, pen_sense_in, conv_done, conv_start, conv_is_x, touched = 1'b0;
    logic        y_drive_en, x_drive_en, pullup_en, precharge_en, panel_ground_return_en, osc_run;
    logic        multipurpose_pin_one, multipurpose_pin_two, ext_clk_tick = 1'b1;
    logic [1:0]  conv_res;
    logic [11:0] conv_data, x_val = 12'h0, y_val = 12'h0;
    logic [3:0]  lat = 4'h1;
    int          failures = 0, check_count = 0, cycles = 0, n, len0, m;
    int          ss[5] = '{1, 3, 3, 0, 0};
    int          dd[5] = '{0, 0, 1, 0, 0};
    always #10 ref_clk = ~ref_clk;
    tps_sequencer u_tps_sequencer (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .ext_clk_tick, .pen_sense_in, .y_drive_en, .x_drive_en, .pullup_en, .precharge_en,
        .panel_ground_return_en, .osc_run, .conv_start, .conv_res, .conv_is_x, .conv_done, .conv_data,
        .multipurpose_pin_one, .multipurpose_pin_two);
    tps_panel_model u_tps_panel_model (.ref_clk, .touched, .pullup_en, .panel_ground_return_en, .conv_start,
        .conv_is_x, .x_val, .y_val, .lat, .pen_sense_in, .conv_done, .conv_data);
    // -------------------------------------------------------
    // tasks
    // -------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check("read data", q, x);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge ref_clk);
    endtask
    function automatic int exp_len(input int k);
        exp_len = 4 * (ss[k] + 1) * (k == 4 ? tps_pkg::OSC_DIV_CYCLES : (1 << dd[k]));
    endfunction
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            complete_run();
        end
    end
    // -------------------------------------------------------
    // scenarios
    // -------------------------------------------------------
    initial
    begin
        void'($urandom(32'h9cdf));
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(8'(i * 4), 32'h0);
        rd(tps_pkg::OFS_STATUS, 32'h20);
        apb(1'b0, 8'h28, 32'h0);
        check("unmapped error", e, 1'b1);
        cyc(2);
        check("idle pins", {pullup_en, panel_ground_return_en, multipurpose_pin_one, multipurpose_pin_two}, 'hc);
        wr(tps_pkg::OFS_PIN_FUNC_ONE, 32'h30);
        cyc(2);
        check("routed pins", {multipurpose_pin_one, multipurpose_pin_two}, 'h2);
        wr(tps_pkg::OFS_PIN_FUNC_TWO, 32'h30);
        wr(tps_pkg::OFS_CLK_SEL, 32'h80);
        for (int k = 0; k < 5; k++)
        begin
            if (k == 4)
                wr(tps_pkg::OFS_CLK_SEL, 32'h0);
            wr(tps_pkg::OFS_SAR_CTRL, (dd[k] << 3) | ((k == 4 ? 0 : $urandom_range(0, 2)) << 5));
            wr(tps_pkg::OFS_STAB_TIMING, ss[k]);
            wr(tps_pkg::OFS_MODE_CTRL, 32'h80 | (k % 4));
            x_val <= 12'($urandom);
            y_val <= 12'($urandom);
            lat <= 4'($urandom_range(1, 9));
            touched <= 1'b1;
            cyc(12);
            check("touch pin", multipurpose_pin_one, k % 4 == 1);
            check("host wait", y_drive_en, 1'b0);
            wr(tps_pkg::OFS_MODE_CTRL, 32'h84 | (k % 4));
            n = 0;
            while (!y_drive_en && n < 500) begin cyc(1); n++; end
            n = 0;
            while (!conv_start && n < 3000) begin cyc(1); n++; end
            if (k == 0)
                len0 = n;
            m = n - len0 - (exp_len(k) - exp_len(0));
            check("stab length", (m < 0 ? -m : m) <= (k == 4 ? 9 : 3), 1'b1);
            n = 0;
            while (!x_drive_en && n < 3000) begin cyc(1); n++; end
            while (x_drive_en && n < 6000) begin cyc(1); n++; end
            cyc(4);
            if (k % 4 == 1 || k % 4 == 2)
                check("ready pin", multipurpose_pin_one, 1'b0);
            rd(tps_pkg::OFS_RESULT_Y, y_val);
            rd(tps_pkg::OFS_RESULT_X, x_val);
            apb(1'b0, tps_pkg::OFS_STATUS, 32'h0);
            check("ready set", q[4], 1'b1);
            apb(1'b0, tps_pkg::OFS_STATUS, 32'h0);
            check("ready cleared", q[4], 1'b0);
            touched <= 1'b0;
            wr(tps_pkg::OFS_MODE_CTRL, 32'h80);
            cyc(20);
        end
        wr(tps_pkg::OFS_MODE_CTRL, 32'h04);
        touched <= 1'b1;
        cyc(12);
        check("touch start", {multipurpose_pin_one, osc_run}, 'h1);
        n = 0;
        repeat (1500) begin cyc(1); n += conv_start && conv_is_x; end
        check("repeated scans", n >= 2, 1'b1);
        wr(tps_pkg::OFS_SAR_CTRL, 32'h80);
        cyc(6);
        n = 0;
        repeat (200) begin cyc(1); n += y_drive_en | x_drive_en | conv_start; end
        check("powered down", n, 0);
        @(posedge ref_clk) touched <= 1'b0;
        cyc(20);
        wr(tps_pkg::OFS_SAR_CTRL, 32'h0);
        wr(tps_pkg::OFS_PEN_TIMING, 32'h80);
        touched <= 1'b1;
        n = 0;
        repeat (300) begin cyc(1); n += y_drive_en | conv_start; end
        check("detect off", n, 0);
        complete_run();
    end
endmodule
bind tps_sequencer tps_seq_asserts u_tps_seq_asserts (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .y_drive_en, .x_drive_en, .pullup_en, .precharge_en, .panel_ground_return_en, .conv_start,
    .conv_is_x, .conv_res);
`default_nettype wire
